// *** verilog/sfs_consts.svh ***
// sfs_consts.svh: offsets-free constants for the supply and bus fault supervisor
// assumes a 20 MHz clock; included by bare name
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_CLK_HZ          20000000
`define SFS_DOM_TMO_US      2000
`define SFS_DOM_TMO_CYC     ((`SFS_DOM_TMO_US * (`SFS_CLK_HZ / 1000000)) + 1)
`define SFS_FAIL_FILT_CYC   200
`define SFS_FAIL_RECOV_CYC  2000
`define SFS_WAKE_FILT_CYC   100
`define SFS_NFAIL           8
`define SFS_CNT_W           17
`endif

// *** verilog/sfs_pkg.sv ***
// sfs_pkg.sv: shared types for the supply and bus fault supervisor
// assumes nothing beyond a SystemVerilog compiler
package sfs_pkg;
    typedef enum logic [2:0] {
        SFS_SYS_AWAIT  = 3'h0,
        SFS_SYS_NORMAL = 3'h1,
        SFS_SYS_STBY   = 3'h2,
        SFS_SYS_SLEEP  = 3'h3,
        SFS_SYS_EMERG  = 3'h4
    } sfs_sys_mode_t;
    typedef enum logic [1:0] {
        SFS_BUS_LOWPWR = 2'h0,
        SFS_BUS_FULL   = 2'h1,
        SFS_BUS_LISTEN = 2'h2
    } sfs_bus_mode_t;
endpackage

// *** verilog/sfs_filt_if.sv ***
// sfs_filt_if.sv: carries one persistence filter's request and answer
// assumes a single clock domain
`timescale 1ns/100ps
interface sfs_filt_if #(parameter int CW = 17);
    logic          cond;
    logic [CW-1:0] limit;
    logic          hit;
    modport owner (output cond, output limit, input hit);
    modport filt  (input cond, input limit, output hit);
endinterface

// *** verilog/sfs_filt.sv ***
// sfs_filt.sv: persistence filter, hit rises once cond holds for limit+1 cycles
// assumes srst synchronous active high, cond synchronous to clock
`timescale 1ns/100ps
module sfs_filt
    import sfs_pkg::*;
#(
    parameter int CW = 17
) (
    input wire logic clock,
    input wire logic srst,
    sfs_filt_if.filt f
);
    logic [CW-1:0] cnt_r;
    logic          hit_r;

    // counter restarts on any drop, so single glitches never accumulate
    always_ff @(posedge clock) begin
        if (srst || !f.cond) begin
            cnt_r <= '0;
        end else if (cnt_r != f.limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= f.cond && (cnt_r == f.limit);
        end
    end

    assign f.hit = hit_r;
endmodule

// *** verilog/sfs_top.sv ***
// sfs_top.sv: supply enable sequencing, status flags and bus fault supervision
// assumes all inputs synchronous to the 20 MHz clock; analog comparators outside
`timescale 1ns/100ps
`include "sfs_consts.svh"

// Functional notes
// - peripheral regulator on only in normal, below shutoff
// - peripheral undervoltage sets status flag
// - peripheral prewarning sets flag and interrupt
// - shutoff sets flag, stays off until software re-enable
// - peripheral off in other modes or main off
// - battery switch on as configured, cyclic in sleep
// - battery switch forced off in await, main off, shutoff
// - switch overtemp flag, off, back on at prewarning
// - battery low sets flag and interrupt
// - battery high sets flag, interrupt, no action
// - failure detection in full and listen modes
// - listen mode: transmitter off, receive shows either
// - failures 3,6 filtered into single wire, recover
// - failures 4,7 drop low line, recover after recessive
// - eight failure flags, interrupt, clear after read
// - transmit dominant too long disables drivers
// - low power: low termination to battery, pulls off
// - bus wake sets interrupt or leaves sleep, recorded
// - wake level must persist for filter time
// - power-up in await mode with bus low power
// - peripheral undervoltage forces bus low power
// - transceiver overtemp disables only transmitter stages
// - full mode enables transmit, receive, detection
// - failures 3,8 open high termination, high driver off
module sfs_top
    import sfs_pkg::*;
#(
    parameter int CW         = `SFS_CNT_W,
    parameter int DOM_TMO    = `SFS_DOM_TMO_CYC,
    parameter int FAIL_FILT  = `SFS_FAIL_FILT_CYC,
    parameter int FAIL_RECOV = `SFS_FAIL_RECOV_CYC,
    parameter int WAKE_FILT  = `SFS_WAKE_FILT_CYC
) (
    input  wire logic                      clock,
    input  wire logic                      srst,
    input  wire sfs_sys_mode_t             sys_mode,
    input  wire logic                      main_regulator_on,
    input  wire logic                      periph_reenable,
    input  wire logic                      periph_uv,
    input  wire logic                      periph_prewarn,
    input  wire logic                      periph_shutoff,
    input  wire logic                      sw_cfg_normal,
    input  wire logic                      sw_cfg_standby,
    input  wire logic                      sw_cfg_cyclic,
    input  wire logic                      cyclic_on_phase,
    input  wire logic                      sw_overtemp,
    input  wire logic                      sw_prewarn,
    input  wire logic                      bat_low,
    input  wire logic                      bat_high,
    input  wire logic                      rd_voltage_switch,
    input  wire logic                      rd_overtemp,
    input  wire logic                      rd_bus_error,
    input  wire logic                      rd_wakeup,
    input  wire logic [7:0]                irq_mask,
    input  wire sfs_bus_mode_t             bus_mode_cmd,
    input  wire logic                      txd_dom,
    input  wire logic                      bus_dom,
    input  wire logic                      canh_dom,
    input  wire logic                      canl_dom,
    input  wire logic [`SFS_NFAIL-1:0]     fail_raw,
    input  wire logic                      xcvr_overtemp,
    output logic                           peripheral_regulator_en,
    output logic                           battery_switch_en,
    output logic [7:0]                     voltage_switch_status_reg,
    output logic [7:0]                     overtemp_status_reg,
    output logic [7:0]                     bus_error_status_high_reg,
    output logic [7:0]                     bus_error_status_low_reg,
    output logic [7:0]                     wakeup_status_reg,
    output logic                           interrupt_out_n,
    output logic                           wake_to_await,
    output sfs_bus_mode_t                  bus_mode_eff,
    output logic                           rxd_dom,
    output logic                           canh_drv_en,
    output logic                           canl_drv_en,
    output logic                           high_term_gnd_en,
    output logic                           low_term_v2_en,
    output logic                           low_term_bat_en,
    output logic                           canl_pullup_en,
    output logic                           canh_pulldown_en,
    output logic                           single_wire_high
);
    // ****************************************************************
    // supply sequencing
    // ****************************************************************
    logic               shut_latch_r;
    logic               sw_hot_r;
    logic [`SFS_NFAIL-1:0] fail_flag_r;
    logic               int_r;

    // shutoff holds the regulator off until software asks again
    always_ff @(posedge clock) begin
        if (srst) begin
            shut_latch_r <= 1'b0;
        end else if (periph_shutoff) begin
            shut_latch_r <= 1'b1;
        end else if (periph_reenable) begin
            shut_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            peripheral_regulator_en <= 1'b0;
        end else begin
            peripheral_regulator_en <= (sys_mode == SFS_SYS_NORMAL) && main_regulator_on
                && !shut_latch_r && !periph_shutoff;
        end
    end

    // switch restarts only after cooling to prewarning, giving hysteresis
    always_ff @(posedge clock) begin
        if (srst) begin
            sw_hot_r <= 1'b0;
        end else if (sw_overtemp) begin
            sw_hot_r <= 1'b1;
        end else if (!sw_prewarn) begin
            sw_hot_r <= 1'b0;
        end
    end

    logic sw_want;
    always_comb begin
        unique case (sys_mode)
            SFS_SYS_NORMAL: sw_want = sw_cfg_normal;
            SFS_SYS_STBY:   sw_want = sw_cfg_standby;
            SFS_SYS_SLEEP:  sw_want = sw_cfg_cyclic && cyclic_on_phase;
            default:        sw_want = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            battery_switch_en <= 1'b0;
        end else begin
            battery_switch_en <= sw_want && main_regulator_on && !shut_latch_r
                && !periph_shutoff && !sw_hot_r && !sw_overtemp;
        end
    end

    // ****************************************************************
    // status flags: set wins over read clear
    // ****************************************************************
    function automatic logic [7:0] sfs_sticky(input logic [7:0] cur, input logic [7:0] set,
                                              input logic rd);
        sfs_sticky = (rd ? 8'h00 : cur) | set;
    endfunction

    always_ff @(posedge clock) begin
        if (srst) begin
            voltage_switch_status_reg <= 8'h00;
            overtemp_status_reg       <= 8'h00;
        end else begin
            voltage_switch_status_reg <= sfs_sticky(voltage_switch_status_reg,
                {4'h0, bat_high, bat_low, sw_overtemp, periph_uv},
                rd_voltage_switch);
            overtemp_status_reg <= sfs_sticky(overtemp_status_reg,
                {6'h00, periph_shutoff, periph_prewarn}, rd_overtemp);
        end
    end

    // ****************************************************************
    // transceiver mode and protection
    // ****************************************************************
    always_comb begin
        bus_mode_eff = periph_uv ? SFS_BUS_LOWPWR : bus_mode_cmd;
    end

    logic detect_on;
    assign detect_on = (bus_mode_eff != SFS_BUS_LOWPWR);

    logic [CW-1:0] dom_cnt_r;
    logic          dom_block_r;
    // block holds while transmit stays dominant, released on recessive
    always_ff @(posedge clock) begin
        if (srst || !txd_dom) begin
            dom_cnt_r   <= '0;
            dom_block_r <= 1'b0;
        end else if (dom_cnt_r == CW'(DOM_TMO)) begin
            dom_block_r <= 1'b1;
        end else begin
            dom_cnt_r <= dom_cnt_r + 1'b1;
        end
    end

    // ****************************************************************
    // failure filters
    // ****************************************************************
    sfs_filt_if #(.CW(CW)) f36_set ();
    sfs_filt_if #(.CW(CW)) f36_clr ();
    sfs_filt_if #(.CW(CW)) f47_set ();
    sfs_filt_if #(.CW(CW)) f47_clr ();
    sfs_filt_if #(.CW(CW)) wk ();

    logic sw36_r;
    logic sw47_r;
    logic c36;
    logic c47;
    assign c36 = detect_on && (fail_raw[2] || fail_raw[5]);
    assign c47 = (fail_raw[3] || fail_raw[6]);

    assign f36_set.cond  = c36 && !sw36_r;
    assign f36_set.limit = CW'(FAIL_FILT);
    assign f36_clr.cond  = sw36_r && !c36;
    assign f36_clr.limit = CW'(FAIL_RECOV);
    assign f47_set.cond  = c47 && !sw47_r;
    assign f47_set.limit = CW'(FAIL_FILT);
    assign f47_clr.cond  = sw47_r && !c47 && !bus_dom;
    assign f47_clr.limit = CW'(FAIL_RECOV);
    assign wk.cond  = (bus_mode_eff == SFS_BUS_LOWPWR) && (canh_dom || canl_dom);
    assign wk.limit = CW'(WAKE_FILT);

    sfs_filt #(.CW(CW)) u_f36s (.clock(clock), .srst(srst), .f(f36_set));
    sfs_filt #(.CW(CW)) u_f36c (.clock(clock), .srst(srst), .f(f36_clr));
    sfs_filt #(.CW(CW)) u_f47s (.clock(clock), .srst(srst), .f(f47_set));
    sfs_filt #(.CW(CW)) u_f47c (.clock(clock), .srst(srst), .f(f47_clr));
    sfs_filt #(.CW(CW)) u_wake (.clock(clock), .srst(srst), .f(wk));

    always_ff @(posedge clock) begin
        if (srst) begin
            sw36_r <= 1'b0;
        end else if (f36_set.hit) begin
            sw36_r <= 1'b1;
        end else if (f36_clr.hit) begin
            sw36_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sw47_r <= 1'b0;
        end else if (f47_set.hit) begin
            sw47_r <= 1'b1;
        end else if (f47_clr.hit) begin
            sw47_r <= 1'b0;
        end
    end

    // ****************************************************************
    // failure flags: set while present, cleared by read once gone
    // ****************************************************************
    logic [`SFS_NFAIL-1:0] fail_seen;
    // low power keeps only failures 3,4,7,8 alive to save current
    assign fail_seen = detect_on ? fail_raw : (fail_raw & 8'hcc);

    genvar gi;
    generate
        for (gi = 0; gi < `SFS_NFAIL; gi++) begin : g_fail
            always_ff @(posedge clock) begin
                if (srst) begin
                    fail_flag_r[gi] <= 1'b0;
                end else if (fail_seen[gi]) begin
                    fail_flag_r[gi] <= 1'b1;
                end else if (rd_bus_error) begin
                    fail_flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign bus_error_status_low_reg  = {4'h0, fail_flag_r[3:0]};
    assign bus_error_status_high_reg = {4'h0, fail_flag_r[7:4]};

    // ****************************************************************
    // wake-up and interrupt
    // ****************************************************************
    logic wake_flag_r;
    always_ff @(posedge clock) begin
        if (srst) begin
            wake_flag_r <= 1'b0;
        end else if (wk.hit) begin
            wake_flag_r <= 1'b1;
        end else if (rd_wakeup) begin
            wake_flag_r <= 1'b0;
        end
    end
    assign wakeup_status_reg = {7'h00, wake_flag_r};

    always_ff @(posedge clock) begin
        if (srst) begin
            wake_to_await <= 1'b0;
        end else begin
            wake_to_await <= wk.hit && (sys_mode == SFS_SYS_SLEEP);
        end
    end

    logic [7:0] irq_src;
    assign irq_src = {3'h0, wake_flag_r && (sys_mode != SFS_SYS_SLEEP), |fail_flag_r,
                      voltage_switch_status_reg[3], voltage_switch_status_reg[2],
                      overtemp_status_reg[0]};

    always_ff @(posedge clock) begin
        if (srst) begin
            int_r <= 1'b0;
        end else begin
            int_r <= |(irq_src & irq_mask);
        end
    end
    assign interrupt_out_n = !int_r;

    // ****************************************************************
    // driver, termination and receive steering
    // ****************************************************************
    logic drv_ok;
    assign drv_ok = (bus_mode_eff == SFS_BUS_FULL) && !dom_block_r
                    && !xcvr_overtemp;

    always_ff @(posedge clock) begin
        if (srst) begin
            canh_drv_en      <= 1'b0;
            canl_drv_en      <= 1'b0;
            high_term_gnd_en <= 1'b0;
            low_term_v2_en   <= 1'b0;
            low_term_bat_en  <= 1'b1;
            canl_pullup_en   <= 1'b0;
            canh_pulldown_en <= 1'b0;
            single_wire_high <= 1'b0;
            rxd_dom          <= 1'b0;
        end else begin
            canh_drv_en      <= drv_ok && !fail_flag_r[2] && !fail_flag_r[7];
            canl_drv_en      <= drv_ok && !sw47_r && !sw36_r;
            high_term_gnd_en <= !fail_flag_r[2] && !fail_flag_r[7];
            low_term_v2_en   <= detect_on && !sw47_r && !sw36_r;
            low_term_bat_en  <= !detect_on && !sw47_r;
            canl_pullup_en   <= detect_on;
            canh_pulldown_en <= detect_on;
            single_wire_high <= sw47_r || sw36_r;
            if (bus_mode_eff == SFS_BUS_LISTEN) begin
                rxd_dom <= txd_dom || bus_dom;
            end else if (bus_mode_eff == SFS_BUS_FULL) begin
                rxd_dom <= bus_dom;
            end else begin
                rxd_dom <= 1'b0;
            end
        end
    end
    // reset state equals the power-up bus low power setting, except high_term_gnd_en, which reset holds off
    // (await mode itself is owned by the mode machine outside)
endmodule

// *** test/sfs_top_assertions.sv ***
// sfs_top_assertions.sv: port-level checks for sfs_top
// assumes one clock and srst synchronous active high; bound below
`timescale 1ns/100ps
module sfs_chk
    import sfs_pkg::*;
#(
    parameter int DOM_TMO = 40001
) (
    input wire logic          clock,
    input wire logic          srst,
    input wire sfs_sys_mode_t sys_mode,
    input wire logic          main_regulator_on,
    input wire logic          periph_shutoff,
    input wire logic          periph_uv,
    input wire logic          sw_overtemp,
    input wire logic          bat_low,
    input wire logic [7:0]    irq_mask,
    input wire logic          txd_dom,
    input wire logic          bus_dom,
    input wire logic [7:0]    fail_raw,
    input wire logic          peripheral_regulator_en,
    input wire logic          battery_switch_en,
    input wire logic [7:0]    voltage_switch_status_reg,
    input wire logic [7:0]    overtemp_status_reg,
    input wire logic          interrupt_out_n,
    input wire sfs_bus_mode_t bus_mode_eff,
    input wire logic          rxd_dom,
    input wire logic          canh_drv_en,
    input wire logic          canl_drv_en,
    input wire logic          low_term_bat_en,
    input wire logic          canl_pullup_en,
    input wire logic          canh_pulldown_en
);
    // ****************
    // helpers
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // saturates so a stuck transmit line cannot wrap the count
    logic [31:0] dom_cnt_r;
    always_ff @(posedge clock) begin
        if (srst || !txd_dom) dom_cnt_r <= 32'h0;
        else if (dom_cnt_r < 32'hffff) dom_cnt_r <= dom_cnt_r + 32'h1;
    end
    sequence s_low_cause;
        bat_low && irq_mask[1];
    endsequence
    sequence s_low_flag_irq;
        voltage_switch_status_reg[2] ##[0:1] !interrupt_out_n;
    endsequence
    // ****************
    // checks
    // ****************
    periph_gate_a: assert property (peripheral_regulator_en |->
        $past(sys_mode) == SFS_SYS_NORMAL && $past(main_regulator_on))
        else $error("peripheral regulator on outside normal");
    shutoff_off_a: assert property (periph_shutoff |=>
        !peripheral_regulator_en && overtemp_status_reg[1])
        else $error("shutoff did not disable regulator");
    sw_forced_a: assert property ((sys_mode == SFS_SYS_AWAIT || !main_regulator_on
        || periph_shutoff) |=> !battery_switch_en)
        else $error("battery switch not forced off");
    sw_hot_off_a: assert property (sw_overtemp |=>
        !battery_switch_en && voltage_switch_status_reg[1])
        else $error("switch overtemp not handled");
    bat_low_irq_a: assert property (s_low_cause |=> s_low_flag_irq)
        else $error("battery low flag or interrupt missing");
    uv_lowpwr_a: assert property (periph_uv |-> bus_mode_eff == SFS_BUS_LOWPWR)
        else $error("undervoltage did not force low power");
    lowpwr_term_a: assert property (bus_mode_eff == SFS_BUS_LOWPWR |=>
        low_term_bat_en && !canl_pullup_en && !canh_pulldown_en)
        else $error("low power termination wrong");
    drv_gate_a: assert property (bus_mode_eff != SFS_BUS_FULL |=>
        !canh_drv_en && !canl_drv_en)
        else $error("drivers on outside full mode");
    listen_rx_a: assert property (bus_mode_eff == SFS_BUS_LISTEN && fail_raw == 8'h00
        && (txd_dom || bus_dom) |=> rxd_dom)
        else $error("listen receive output not dominant");
    dom_tmo_a: assert property (dom_cnt_r > DOM_TMO + 3 |->
        !canh_drv_en && !canl_drv_en)
        else $error("drivers on after dominant timeout");
endmodule

bind sfs_top sfs_chk #(.DOM_TMO(DOM_TMO)) u_chk (.*);

// *** test/sfs_ctl_model.sv ***
// sfs_ctl_model.sv: protocol controller stand-in on the transmit and receive pins
// assumes one clock; the bench asks for dominant bits between edges
`timescale 1ns/100ps
module sfs_ctl_model (
    input  wire logic clock,
    input  wire logic send_dom,
    input  wire logic rxd_dom,
    output logic      txd_dom,
    output logic      echo_seen
);
    // launched just after the edge so the supervisor never samples a change
    initial txd_dom = 1'b0;
    always @(posedge clock) txd_dom <= #2 send_dom;
    always @(posedge clock) echo_seen <= rxd_dom;
endmodule

// *** test/tb_top.sv ***
// tb_top.sv: directed bench for sfs_top with a controller stand-in
// assumes short filter counts so the whole run takes a few hundred cycles
`timescale 1ns/100ps
module tb_top;
    import sfs_pkg::*;
    localparam int DT = 20, FF = 4, FR = 4, WF = 4;
    logic clock = 1'b0, srst = 1'b1, send_dom = 1'b0;
    sfs_sys_mode_t sys_mode = SFS_SYS_AWAIT;
    sfs_bus_mode_t bus_mode_cmd = SFS_BUS_LOWPWR;
    logic main_regulator_on = 1'b0, periph_reenable = 1'b0, periph_uv = 1'b0;
    logic periph_prewarn = 1'b0, periph_shutoff = 1'b0, sw_cfg_normal = 1'b1;
    logic sw_cfg_standby = 1'b1, sw_cfg_cyclic = 1'b0, cyclic_on_phase = 1'b0;
    logic sw_overtemp = 1'b0, sw_prewarn = 1'b0, bat_low = 1'b0, bat_high = 1'b0;
    logic bus_dom = 1'b0, canh_dom = 1'b0, canl_dom = 1'b0, xcvr_overtemp = 1'b0;
    logic [7:0] irq_mask = 8'h00, fail_raw = 8'h00;
    logic [3:0] rd_v = 4'h0;
    wire logic rd_voltage_switch = rd_v[0], rd_overtemp = rd_v[1];
    wire logic rd_bus_error = rd_v[2], rd_wakeup = rd_v[3];
    logic [7:0] voltage_switch_status_reg, overtemp_status_reg, wakeup_status_reg;
    logic [7:0] bus_error_status_high_reg, bus_error_status_low_reg;
    logic peripheral_regulator_en, battery_switch_en, interrupt_out_n, wake_to_await;
    logic rxd_dom, canh_drv_en, canl_drv_en, high_term_gnd_en, low_term_v2_en;
    logic low_term_bat_en, canl_pullup_en, canh_pulldown_en, single_wire_high;
    logic txd_dom, echo_seen;
    sfs_bus_mode_t bus_mode_eff;
    sfs_sys_mode_t offm [4] = '{SFS_SYS_AWAIT, SFS_SYS_STBY, SFS_SYS_SLEEP, SFS_SYS_EMERG};
    int checks = 0, miscompares = 0;

    always #25 clock = ~clock;
    sfs_top #(.DOM_TMO(DT), .FAIL_FILT(FF), .FAIL_RECOV(FR), .WAKE_FILT(WF)) DUT (.*);
    sfs_ctl_model u_ctl (.clock(clock), .send_dom(send_dom), .rxd_dom(rxd_dom),
                         .txd_dom(txd_dom), .echo_seen(echo_seen));

    // ****************
    // access tasks
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a read clears only flags whose cause has gone
    task automatic rd(input int i);
        rd_v[i] = 1'b1;
        step(1);
        rd_v = 4'h0;
        step(2);
    endtask
    task automatic wait_hi(input bit sel);
        int k;
        for (k = 0; k < 40; k++) begin
            if ((sel ? wake_to_await : wakeup_status_reg[0]) === 1'b1) return;
            step(1);
        end
        miscompares++;
        close_out();
    endtask
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        step(20);
        srst = 1'b0;
        chk({low_term_bat_en, interrupt_out_n, peripheral_regulator_en, bus_mode_eff},
            8'h18);
        main_regulator_on = 1'b1;
        sys_mode = SFS_SYS_NORMAL;
        step(2);
        chk({peripheral_regulator_en, battery_switch_en}, 8'h03);
        foreach (offm[m]) begin
            sys_mode = offm[m];
            step(2);
            chk(peripheral_regulator_en, 8'h00);
        end
        sys_mode = SFS_SYS_NORMAL;
        main_regulator_on = 1'b0;
        step(2);
        chk({peripheral_regulator_en, battery_switch_en}, 8'h00);
        main_regulator_on = 1'b1;
        step(2);
        periph_shutoff = 1'b1;
        step(1);
        periph_shutoff = 1'b0;
        chk({peripheral_regulator_en, overtemp_status_reg[1]}, 8'h01);
        step(5);
        chk({peripheral_regulator_en, battery_switch_en}, 8'h00);
        periph_reenable = 1'b1;
        step(1);
        periph_reenable = 1'b0;
        step(2);
        chk(peripheral_regulator_en, 8'h01);
        irq_mask = 8'h01;
        periph_prewarn = 1'b1;
        step(3);
        chk({overtemp_status_reg[0], interrupt_out_n}, 8'h02);
        periph_prewarn = 1'b0;
        rd(1);
        chk({overtemp_status_reg[0], interrupt_out_n}, 8'h01);
        step(2);
        sw_overtemp = 1'b1;
        step(1);
        chk({battery_switch_en, voltage_switch_status_reg[1]}, 8'h01);
        sw_overtemp = 1'b0;
        sw_prewarn = 1'b1;
        step(2);
        chk(battery_switch_en, 8'h00);
        sw_prewarn = 1'b0;
        step(2);
        chk(battery_switch_en, 8'h01);
        sw_cfg_cyclic = 1'b1;
        sys_mode = SFS_SYS_SLEEP;
        cyclic_on_phase = 1'b1;
        step(2);
        chk(battery_switch_en, 8'h01);
        cyclic_on_phase = 1'b0;
        step(2);
        chk(battery_switch_en, 8'h00);
        sys_mode = SFS_SYS_AWAIT;
        cyclic_on_phase = 1'b1;
        step(2);
        chk(battery_switch_en, 8'h00);
        sys_mode = SFS_SYS_NORMAL;
        rd(0);
        irq_mask = 8'h06;
        bat_low = 1'b1;
        step(3);
        chk({voltage_switch_status_reg[3:2], interrupt_out_n}, 8'h02);
        bat_low = 1'b0;
        bat_high = 1'b1;
        step(3);
        chk({voltage_switch_status_reg[3], peripheral_regulator_en}, 8'h03);
        bat_high = 1'b0;
        rd(0);
        chk({voltage_switch_status_reg[3:0], interrupt_out_n}, 8'h01);
        irq_mask = 8'h00;
        bat_low = 1'b1;
        step(3);
        chk(interrupt_out_n, 8'h01);
        bat_low = 1'b0;
        periph_uv = 1'b1;
        bus_mode_cmd = SFS_BUS_FULL;
        step(2);
        chk({voltage_switch_status_reg[0], bus_mode_eff}, 8'h04);
        periph_uv = 1'b0;
        rd(0);
        chk({bus_mode_eff, canh_drv_en, canl_drv_en}, 8'h07);
        xcvr_overtemp = 1'b1;
        bus_dom = 1'b1;
        step(2);
        chk({canh_drv_en, canl_drv_en, rxd_dom}, 8'h01);
        xcvr_overtemp = 1'b0;
        bus_dom = 1'b0;
        send_dom = 1'b1;
        step(DT + 8);
        chk({canh_drv_en, canl_drv_en}, 8'h00);
        send_dom = 1'b0;
        step(3);
        bus_mode_cmd = SFS_BUS_LISTEN;
        send_dom = 1'b1;
        step(4);
        chk({canh_drv_en, canl_drv_en, rxd_dom, echo_seen}, 8'h03);
        send_dom = 1'b0;
        bus_dom = 1'b1;
        step(3);
        chk(rxd_dom, 8'h01);
        bus_dom = 1'b0;
        bus_mode_cmd = SFS_BUS_FULL;
        irq_mask = 8'h08;
        for (int i = 0; i < 8; i++) begin
            fail_raw = 8'h01 << i;
            step(FF + FR + 4);
            chk({bus_error_status_high_reg[3:0], bus_error_status_low_reg[3:0]},
                8'h01 << i);
            chk(interrupt_out_n, 8'h00);
            if (i == 2) chk({high_term_gnd_en, canh_drv_en}, 8'h00);
            if (i == 3) chk({low_term_v2_en, canl_drv_en, single_wire_high}, 8'h01);
            fail_raw = 8'h00;
            step(FR + FF + 10);
            rd(2);
            chk({bus_error_status_high_reg[3:0], bus_error_status_low_reg[3:0]},
                8'h00);
            chk({canh_drv_en, canl_drv_en, single_wire_high}, 8'h06);
        end
        bus_mode_cmd = SFS_BUS_LOWPWR;
        sys_mode = SFS_SYS_STBY;
        irq_mask = 8'h10;
        step(2);
        chk({low_term_bat_en, canl_pullup_en, canh_pulldown_en}, 8'h04);
        canh_dom = 1'b1;
        step(2);
        canh_dom = 1'b0;
        step(WF + 4);
        chk(wakeup_status_reg[0], 8'h00);
        canl_dom = 1'b1;
        wait_hi(1'b0);
        step(1);
        chk({interrupt_out_n, wake_to_await}, 8'h00);
        canl_dom = 1'b0;
        // let the filter drop first, else the set wins over the read
        step(1);
        rd(3);
        chk(wakeup_status_reg[0], 8'h00);
        sys_mode = SFS_SYS_SLEEP;
        canh_dom = 1'b1;
        wait_hi(1'b1);
        chk({wakeup_status_reg[0], interrupt_out_n}, 8'h03);
        close_out();
    end
endmodule
